// ===== rtl/dic_input_cond.sv
// digital input conditioning, diagnostics and operation counters with wishbone registers
`timescale 1ns/1ps

// Behaviour
// - supply short raises unit error only while supply short monitoring enabled (default on).
// - disconnected channel raises per-channel error only while open circuit monitoring enabled.
// - with inrush masking on, overcurrent ignored for 100 ms after an inrush.
// - input changes shorter than selected filter time (0.1/1/10/20 ms) are ignored.
// - detected input held for selected extension time; 15 ms after reset.
// - off-to-on edges counted per channel; error beyond threshold when counter enabled.
// - threshold compared as setting times one thousand operations.
// - every hour each channel count is written to non-volatile storage.
// - after power-up counts resume from values restored from storage.
module dic_input_cond
    import dic_pkg::*;
#(
    parameter int CHANNELS = 8,
    parameter int unsigned FILT_01MS_CYC = FILT_01MS_US * CLK_MHZ,
    parameter int unsigned FILT_1MS_CYC = FILT_1MS_US * CLK_MHZ,
    parameter int unsigned FILT_10MS_CYC = FILT_10MS_US * CLK_MHZ,
    parameter int unsigned FILT_20MS_CYC = FILT_20MS_US * CLK_MHZ,
    parameter int unsigned EXT_1MS_CYC = EXT_1MS_US * CLK_MHZ,
    parameter int unsigned EXT_10MS_CYC = EXT_10MS_US * CLK_MHZ,
    parameter int unsigned EXT_15MS_CYC = EXT_15MS_US * CLK_MHZ,
    parameter int unsigned EXT_200MS_CYC = EXT_200MS_US * CLK_MHZ,
    parameter int unsigned INRUSH_CYC = INRUSH_MS * CLK_MHZ * 1000,
    parameter longint unsigned SAVE_CYC = 64'(SAVE_PERIOD_S) * CLK_HZ
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // wishbone slave
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [7:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic wb_ack_out,
    output logic [31:0] wb_dat_out,
    // field side
    input wire logic [CHANNELS-1:0] raw_in,
    input wire logic [CHANNELS-1:0] open_circuit_in,
    input wire logic supply_short_in,
    input wire logic overcurrent_in,
    input wire logic inrush_start_in,
    output logic [CHANNELS-1:0] cond_out,
    output logic irq_out,
    // non-volatile storage
    input wire logic nv_load_valid_in,
    input wire logic [7:0] nv_load_chan_in,
    input wire logic [31:0] nv_load_data_in,
    input wire logic nv_load_done_in,
    output dic_nv_save_t nv_save_out
);

    // ***************************************************
    // state
    // ***************************************************
    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        dic_ctrl_t ctrl;
        logic [15:0] thresh;
        logic [7:0] cnt_sel;
        logic [IRQ_BITS-1:0] irq_stat;
        logic [IRQ_BITS-1:0] irq_mask;
        logic irq;
        logic [CHANNELS-1:0] stable;
        logic [CHANNELS-1:0][31:0] filt_cnt;
        logic [CHANNELS-1:0][31:0] ext_cnt;
        logic [CHANNELS-1:0] cond;
        logic [CHANNELS-1:0][31:0] opcnt;
        logic sc_err;
        logic ovc_err;
        logic [CHANNELS-1:0] oc_err;
        logic [CHANNELS-1:0] cnt_err;
        logic [IRQ_BITS-1:0] ev_prev;
        logic [31:0] inrush_cnt;
        logic [63:0] hour_cnt;
        dic_fsm_t fsm;
        logic [7:0] save_idx;
        dic_nv_save_t nv;
    } dic_state_t;

    dic_state_t s_q;
    dic_state_t s_d;

    function automatic logic [31:0] filt_cyc(input logic [1:0] sel);
        case (sel)
            2'h0: filt_cyc = 32'(FILT_01MS_CYC);
            2'h1: filt_cyc = 32'(FILT_1MS_CYC);
            2'h2: filt_cyc = 32'(FILT_10MS_CYC);
            default: filt_cyc = 32'(FILT_20MS_CYC);
        endcase
    endfunction : filt_cyc

    function automatic logic [31:0] ext_cyc(input logic [1:0] sel);
        case (sel)
            2'h0: ext_cyc = 32'(EXT_1MS_CYC);
            2'h1: ext_cyc = 32'(EXT_10MS_CYC);
            2'h2: ext_cyc = 32'(EXT_15MS_CYC);
            default: ext_cyc = 32'(EXT_200MS_CYC);
        endcase
    endfunction : ext_cyc

    // byte lanes left unselected keep their old value
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        merge = (old & ~m) | (dat & m);
    endfunction : merge

    logic [31:0] thr_scaled;
    logic [31:0] fcyc;
    logic [31:0] ecyc;
    assign thr_scaled = 32'(s_q.thresh) * THRESH_SCALE;
    assign fcyc = filt_cyc(s_q.ctrl.filter_time);
    assign ecyc = ext_cyc(s_q.ctrl.input_extension_time);

    // ***************************************************
    // next state
    // ***************************************************
    always_comb begin
        logic req;
        logic [31:0] wv;
        logic [IRQ_BITS-1:0] ev;
        req = 1'b0;
        wv = '0;
        ev = '0;
        s_d = s_q;
        s_d.nv.valid = 1'b0;

        // wishbone: one wait state, ack pulse, unmapped reads zero
        req = wb_cyc_in && wb_stb_in && !s_q.ack;
        s_d.ack = req;
        s_d.rdat = '0;
        if (req && !wb_we_in) begin
            case (wb_adr_in)
                ADDR_CTRL: s_d.rdat = 32'(s_q.ctrl);
                ADDR_THRESH: s_d.rdat = 32'(s_q.thresh);
                ADDR_INPUT: s_d.rdat = 32'(s_q.cond);
                ADDR_UNIT_STAT: s_d.rdat = 32'({s_q.ovc_err, s_q.sc_err});
                ADDR_OPEN_STAT: s_d.rdat = 32'(s_q.oc_err);
                ADDR_CNT_STAT: s_d.rdat = 32'(s_q.cnt_err);
                ADDR_IRQ_STAT: s_d.rdat = 32'(s_q.irq_stat);
                ADDR_IRQ_MASK: s_d.rdat = 32'(s_q.irq_mask);
                ADDR_CNT_SEL: s_d.rdat = 32'(s_q.cnt_sel);
                ADDR_CNT_VAL: s_d.rdat = (32'(s_q.cnt_sel) < CHANNELS) ? s_q.opcnt[s_q.cnt_sel] : '0;
                default: s_d.rdat = '0;
            endcase
            // read clears status; events below still win
            if (wb_adr_in == ADDR_IRQ_STAT) begin
                s_d.irq_stat = '0;
            end
        end
        // writes land at the ack edge, while the master still holds address and data
        if (wb_cyc_in && wb_stb_in && wb_we_in && s_q.ack) begin
            case (wb_adr_in)
                ADDR_CTRL: begin
                    wv = merge(32'(s_q.ctrl), wb_dat_in, wb_sel_in);
                    s_d.ctrl = wv[$bits(dic_ctrl_t)-1:0];
                end
                ADDR_THRESH: begin
                    wv = merge(32'(s_q.thresh), wb_dat_in, wb_sel_in);
                    if (wv[31:16] == '0 && wv[15:0] >= THRESH_MIN && wv[15:0] <= THRESH_MAX) begin
                        s_d.thresh = wv[15:0];
                    end
                end
                ADDR_IRQ_MASK: begin
                    wv = merge(32'(s_q.irq_mask), wb_dat_in, wb_sel_in);
                    s_d.irq_mask = wv[IRQ_BITS-1:0];
                end
                ADDR_CNT_SEL: begin
                    wv = merge(32'(s_q.cnt_sel), wb_dat_in, wb_sel_in);
                    s_d.cnt_sel = wv[7:0];
                end
                default: s_d.cnt_sel = s_q.cnt_sel;
            endcase
        end

        // per channel conditioning
        for (int i = 0; i < CHANNELS; i++) begin
            // accept only changes lasting the filter time
            if (raw_in[i] == s_q.stable[i]) begin
                s_d.filt_cnt[i] = '0;
            end else if (s_q.filt_cnt[i] >= fcyc - 32'h1) begin
                s_d.stable[i] = raw_in[i];
                s_d.filt_cnt[i] = '0;
            end else begin
                s_d.filt_cnt[i] = s_q.filt_cnt[i] + 32'h1;
            end
            if (s_q.stable[i]) begin
                s_d.ext_cnt[i] = ecyc;
            end else if (s_q.ext_cnt[i] != '0) begin
                s_d.ext_cnt[i] = s_q.ext_cnt[i] - 32'h1;
            end
            s_d.cond[i] = s_q.stable[i] || (s_q.ext_cnt[i] != '0);
            // count off-to-on edges, saturating
            // saturating so a worn channel never reads as fresh
            if (s_d.stable[i] && !s_q.stable[i] && s_q.opcnt[i] != '1) begin
                s_d.opcnt[i] = s_q.opcnt[i] + 32'h1;
            end
            s_d.cnt_err[i] = s_q.ctrl.counter_enable && (s_q.opcnt[i] > thr_scaled);
        end

        // supply short gated by its enable
        s_d.sc_err = s_q.ctrl.supply_short_monitor_enable && supply_short_in;
        s_d.oc_err = s_q.ctrl.open_circuit_monitor_enable ? open_circuit_in : '0;
        // inrush window masks overcurrent
        // a repeated inrush pulse restarts the window
        if (inrush_start_in) begin
            s_d.inrush_cnt = 32'(INRUSH_CYC);
        end else if (s_q.inrush_cnt != '0) begin
            s_d.inrush_cnt = s_q.inrush_cnt - 32'h1;
        end
        s_d.ovc_err = overcurrent_in && !(s_q.ctrl.inrush_mask_enable && s_q.inrush_cnt != '0);

        // sticky events from rising error flags
        ev[IRQ_SUPPLY] = s_q.sc_err;
        ev[IRQ_OVERCUR] = s_q.ovc_err;
        ev[IRQ_OPEN] = |s_q.oc_err;
        ev[IRQ_COUNT] = |s_q.cnt_err;
        s_d.ev_prev = ev;
        s_d.irq_stat = s_d.irq_stat | (ev & ~s_q.ev_prev);
        // one cycle lag keeps irq a plain flop output
        s_d.irq = |(s_q.irq_stat & s_q.irq_mask);

        // persistence sequencing
        case (s_q.fsm)
            DIC_ST_RESTORE: begin
                if (nv_load_valid_in && 32'(nv_load_chan_in) < CHANNELS) begin
                    s_d.opcnt[nv_load_chan_in] = nv_load_data_in;
                end
                if (nv_load_done_in) begin
                    s_d.fsm = DIC_ST_RUN;
                    s_d.hour_cnt = SAVE_CYC - 64'h1;
                end
            end
            DIC_ST_RUN: begin
                if (s_q.hour_cnt == '0) begin
                    s_d.fsm = DIC_ST_SAVE;
                    s_d.save_idx = '0;
                    s_d.hour_cnt = SAVE_CYC - 64'h1;
                end else begin
                    s_d.hour_cnt = s_q.hour_cnt - 64'h1;
                end
            end
            DIC_ST_SAVE: begin
                s_d.nv.valid = 1'b1;
                s_d.nv.chan = s_q.save_idx;
                s_d.nv.data = s_q.opcnt[s_q.save_idx];
                s_d.hour_cnt = s_q.hour_cnt - 64'h1;
                s_d.save_idx = s_q.save_idx + 8'h01;
                if (32'(s_q.save_idx) == CHANNELS - 1) begin
                    s_d.fsm = DIC_ST_RUN;
                end
            end
            default: s_d.fsm = DIC_ST_RUN;
        endcase
    end

    // ***************************************************
    // registers and outputs
    // ***************************************************
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            s_q <= '0;
            s_q.ctrl <= CTRL_RST;
            s_q.thresh <= THRESH_RST;
            s_q.fsm <= DIC_ST_RESTORE;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_ack_out = s_q.ack;
    assign wb_dat_out = s_q.rdat;
    assign cond_out = s_q.cond;
    assign irq_out = s_q.irq;
    assign nv_save_out = s_q.nv;

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    supply_short_err_a: assert property (
        s_q.ctrl.supply_short_monitor_enable && supply_short_in |=> s_q.sc_err)
        else $error("supply short not flagged");
    open_gate_a: assert property (
        !s_q.ctrl.open_circuit_monitor_enable |=> s_q.oc_err == '0)
        else $error("open circuit flagged while disabled");
    inrush_mask_a: assert property (
        s_q.ctrl.inrush_mask_enable && s_q.inrush_cnt != '0 |=> !s_q.ovc_err)
        else $error("overcurrent seen inside inrush window");
    filter_hold_a: assert property (
        raw_in[1] == s_q.stable[1] |=> $stable(s_q.stable[1]))
        else $error("filtered input moved without raw change");
    extension_hold_a: assert property (
        $fell(s_q.stable[1]) |-> s_q.cond[1] ##1 s_q.cond[1])
        else $error("input not held after release");
    count_err_a: assert property (
        s_q.ctrl.counter_enable && s_q.opcnt[3] > thr_scaled |=> s_q.cnt_err[3])
        else $error("counter error missing above threshold");
    thresh_range_a: assert property (
        $changed(s_q.thresh) |-> s_q.thresh >= THRESH_MIN && s_q.thresh <= THRESH_MAX)
        else $error("threshold left its range");
    hourly_save_a: assert property (
        s_q.fsm == DIC_ST_RUN && s_q.hour_cnt == '0 |=> s_q.fsm == DIC_ST_SAVE ##1 s_q.nv.valid)
        else $error("hourly save not started");
    restore_load_a: assert property (
        s_q.fsm == DIC_ST_RESTORE && nv_load_valid_in && nv_load_chan_in == 8'h00
        |=> s_q.opcnt[0] == $past(nv_load_data_in))
        else $error("restored count not taken");
    count_gate_a: assert property (
        !s_q.ctrl.counter_enable |=> s_q.cnt_err == '0)
        else $error("counter error while disabled");
    irq_level_a: assert property (
        |(s_q.irq_stat & s_q.irq_mask) |=> s_q.irq)
        else $error("interrupt not raised for unmasked status");
    op_count_a: assert property (
        $rose(s_q.stable[1]) && $past(s_q.fsm) != DIC_ST_RESTORE && $past(s_q.opcnt[1]) != 32'hFFFF_FFFF
        |-> s_q.opcnt[1] == $past(s_q.opcnt[1]) + 32'h1)
        else $error("accepted off-to-on edge not counted");

    filter_accept_c: cover property ($changed(s_q.stable[1]));
    save_run_c: cover property (s_q.fsm == DIC_ST_SAVE);
    count_err_c: cover property ($rose(s_q.cnt_err[3]));
    irq_raise_c: cover property ($rose(s_q.irq));
    inrush_mask_c: cover property (s_q.ctrl.inrush_mask_enable && s_q.inrush_cnt != '0 && overcurrent_in);

endmodule : dic_input_cond

// ===== rtl/dic_pkg.sv
// shared constants and carrier types of the digital input conditioning block
package dic_pkg;

    // ***************************************************
    // clock and time figures
    // ***************************************************
    localparam int CLK_MHZ = 100;
    localparam longint unsigned CLK_HZ = 64'd100_000_000;
    localparam int FILT_01MS_US = 100;
    localparam int FILT_1MS_US = 1000;
    localparam int FILT_10MS_US = 10000;
    localparam int FILT_20MS_US = 20000;
    localparam int EXT_1MS_US = 1000;
    localparam int EXT_10MS_US = 10000;
    localparam int EXT_15MS_US = 15000;
    localparam int EXT_200MS_US = 200000;
    localparam int INRUSH_MS = 100;
    localparam int SAVE_PERIOD_S = 3600;

    // ***************************************************
    // register map, byte addresses
    // ***************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_THRESH = 8'h04;
    localparam logic [7:0] ADDR_INPUT = 8'h08;
    localparam logic [7:0] ADDR_UNIT_STAT = 8'h0C;
    localparam logic [7:0] ADDR_OPEN_STAT = 8'h10;
    localparam logic [7:0] ADDR_CNT_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C;
    localparam logic [7:0] ADDR_CNT_SEL = 8'h20;
    localparam logic [7:0] ADDR_CNT_VAL = 8'h24;

    // ***************************************************
    // fields and reset values
    // ***************************************************
    localparam logic [15:0] THRESH_MIN = 16'h0001;
    localparam logic [15:0] THRESH_MAX = 16'hFDE8;
    localparam logic [15:0] THRESH_RST = 16'h0001;
    localparam logic [31:0] THRESH_SCALE = 32'h0000_03E8;
    localparam int IRQ_BITS = 4;
    localparam int IRQ_SUPPLY = 0;
    localparam int IRQ_OVERCUR = 1;
    localparam int IRQ_OPEN = 2;
    localparam int IRQ_COUNT = 3;

    // control register, bit 0 upward: sc, oc, inrush, counter, filter[5:4], extension[7:6]
    typedef struct packed {
        logic [1:0] input_extension_time;
        logic [1:0] filter_time;
        logic counter_enable;
        logic inrush_mask_enable;
        logic open_circuit_monitor_enable;
        logic supply_short_monitor_enable;
    } dic_ctrl_t;
    localparam dic_ctrl_t CTRL_RST = 8'h91;

    // save port towards non-volatile storage
    typedef struct packed {
        logic valid;
        logic [7:0] chan;
        logic [31:0] data;
    } dic_nv_save_t;

    typedef enum logic [1:0] {
        DIC_ST_RESTORE = 2'b00,
        DIC_ST_RUN = 2'b01,
        DIC_ST_SAVE = 2'b11
    } dic_fsm_t;

endpackage : dic_pkg

// ===== test/dic_field_model.sv
// field-side partner: restores saved counts at power-up and records hourly saves
`timescale 1ns/1ps
module dic_field_model
    import dic_pkg::*;
#(
    parameter int CHANNELS = 8
) (
    // clock and reset
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    // storage side
    output logic nv_load_valid_out,
    output logic [7:0] nv_load_chan_out,
    output logic [31:0] nv_load_data_out,
    output logic nv_load_done_out,
    input wire dic_nv_save_t nv_save_in
);
    logic [31:0] saved [CHANNELS];
    int save_cnt;
    initial begin
        nv_load_valid_out = 1'b0;
        nv_load_chan_out = 8'h00;
        nv_load_data_out = 32'h0000_0000;
        nv_load_done_out = 1'b0;
        save_cnt = 0;
        wait (reset_n_in === 1'b1);
        @(posedge clk_sys_in);
        nv_load_valid_out <= 1'b1;
        nv_load_data_out <= 32'h0000_0005;
        @(posedge clk_sys_in);
        nv_load_chan_out <= 8'h03;
        nv_load_data_out <= 32'h0000_03E8;
        @(posedge clk_sys_in);
        // idle lines show no stale value
        nv_load_valid_out <= 1'b0;
        nv_load_data_out <= 32'hFFFF_FC17;
        nv_load_chan_out <= 8'hFC;
        nv_load_done_out <= 1'b1;
    end
    always @(posedge clk_sys_in) begin
        if (nv_save_in.valid === 1'b1 && nv_save_in.chan < CHANNELS) begin
            saved[nv_save_in.chan] <= nv_save_in.data;
            save_cnt <= save_cnt + 1;
        end
    end
endmodule : dic_field_model

// ===== test/testbench.sv
// self-checking testbench of the digital input conditioning block
`timescale 1ns/1ps
module testbench;
    import dic_pkg::*;
    localparam int N = 8;
    localparam int FILT = 8;
    localparam int FILT_F = 4;
    localparam int FILT_L = 16;
    localparam int EXT = 20;
    localparam int EXT_S = 8;
    localparam int EXT_L = 40;
    localparam int INR = 50;
    localparam int SAVE = 400;
    logic clk_sys_in, reset_n_in, cyc, stb, we, ack, irq, sshort, ocur, inrush, ld_v, ld_done;
    logic [7:0] adr, ld_c;
    logic [3:0] sel;
    logic [31:0] wdat, rdat_w, ld_dat, rd;
    logic [N-1:0] raw, open_c, cond;
    dic_nv_save_t save;
    int fail_count, cmp_count;
    // ***************************************************
    // design and partner
    // ***************************************************
    dic_input_cond #(.CHANNELS(N), .FILT_01MS_CYC(FILT_F), .FILT_1MS_CYC(FILT), .FILT_10MS_CYC(12),
        .FILT_20MS_CYC(FILT_L), .EXT_1MS_CYC(EXT_S), .EXT_10MS_CYC(12), .EXT_15MS_CYC(EXT),
        .EXT_200MS_CYC(EXT_L), .INRUSH_CYC(INR), .SAVE_CYC(SAVE)) dic_input_cond_i (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
        .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_ack_out(ack),
        .wb_dat_out(rdat_w), .raw_in(raw), .open_circuit_in(open_c), .supply_short_in(sshort),
        .overcurrent_in(ocur), .inrush_start_in(inrush), .cond_out(cond), .irq_out(irq),
        .nv_load_valid_in(ld_v), .nv_load_chan_in(ld_c), .nv_load_data_in(ld_dat),
        .nv_load_done_in(ld_done), .nv_save_out(save));
    dic_field_model #(.CHANNELS(N)) dic_field_model_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .nv_load_valid_out(ld_v), .nv_load_chan_out(ld_c), .nv_load_data_out(ld_dat),
        .nv_load_done_out(ld_done), .nv_save_in(save));
    // ***************************************************
    // tasks
    // ***************************************************
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one classic cycle; ack may come at any edge, a hang is cut at 50
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (ack !== 1'b1 && n < 50);
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        rd = rdat_w;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_sys_in);
    endtask : wb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        wb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask : rdchk
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask : wt
    task automatic pulse(input int ch);
        raw[ch] <= 1'b1;
        wt(20);
        raw[ch] <= 1'b0;
        wt(FILT + EXT + 10);
    endtask : pulse
    // ***************************************************
    // clock, watchdog, tests
    // ***************************************************
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        #100us;
        fail_count++;
        report_and_stop();
    end
    initial begin
        {cyc, stb, we, sshort, ocur, inrush} = 6'h00;
        {adr, sel, wdat, raw, open_c} = 60'h0;
        sel = 4'hF;
        fail_count = 0;
        cmp_count = 0;
        reset_n_in = 1'b0;
        wt(2);
        reset_n_in <= 1'b1;
        @(posedge clk_sys_in);
        rdchk(ADDR_CTRL, 32'h0000_0091, "ctrl reset");
        rdchk(ADDR_THRESH, 32'h0000_0001, "thresh reset");
        rdchk(8'h30, 32'h0000_0000, "unmapped read");
        wt(4);
        wb(1'b1, ADDR_CNT_SEL, 32'h0);
        rdchk(ADDR_CNT_VAL, 32'h0000_0005, "restored count");
        $display("test reset and restore done");
        // short change is swallowed, long one counted and held
        raw[1] <= 1'b1;
        wt(3);
        raw[1] <= 1'b0;
        wt(12);
        chk("glitch cond", 32'h0, 32'(cond));
        raw[1] <= 1'b1;
        wt(20);
        chk("cond on", 32'h2, 32'(cond));
        raw[1] <= 1'b0;
        wt(FILT + 10);
        chk("cond held", 32'h2, 32'(cond));
        wt(EXT);
        chk("cond released", 32'h0, 32'(cond));
        wb(1'b1, ADDR_CNT_SEL, 32'h1);
        rdchk(ADDR_CNT_VAL, 32'h0000_0001, "ch1 count");
        $display("test filter and extension done");
        wb(1'b1, ADDR_THRESH, 32'h0);
        wb(1'b1, ADDR_THRESH, 32'h0000_FDE9);
        rdchk(ADDR_THRESH, 32'h0000_0001, "thresh refused");
        wb(1'b1, ADDR_THRESH, 32'h0000_FDE8);
        rdchk(ADDR_THRESH, 32'h0000_FDE8, "thresh max");
        sel <= 4'h1;
        wb(1'b1, ADDR_THRESH, 32'h0000_0005);
        sel <= 4'hF;
        rdchk(ADDR_THRESH, 32'h0000_FD05, "thresh lane merge");
        wb(1'b1, ADDR_THRESH, 32'h1);
        wb(1'b1, ADDR_CTRL, 32'h99);
        rdchk(ADDR_CNT_STAT, 32'h0, "count at limit");
        pulse(3);
        rdchk(ADDR_CNT_STAT, 32'h8, "count above limit");
        $display("test threshold done");
        wb(1'b0, ADDR_IRQ_STAT, 32'h0);
        wb(1'b1, ADDR_IRQ_MASK, 32'h1);
        sshort <= 1'b1;
        wt(3);
        rdchk(ADDR_UNIT_STAT, 32'h1, "supply short");
        chk("irq raised", 32'h1, 32'(irq));
        wb(1'b0, ADDR_IRQ_STAT, 32'h0);
        chk("irq status", 32'h1, rd & 32'h1);
        wt(2);
        chk("irq cleared", 32'h0, 32'(irq));
        wb(1'b1, ADDR_CTRL, 32'h98);
        rdchk(ADDR_UNIT_STAT, 32'h0, "short unmonitored");
        sshort <= 1'b0;
        open_c <= 8'h04;
        wt(2);
        rdchk(ADDR_OPEN_STAT, 32'h0, "open unmonitored");
        wb(1'b1, ADDR_CTRL, 32'h9A);
        rdchk(ADDR_OPEN_STAT, 32'h4, "open ch2");
        $display("test diagnostics done");
        wb(1'b1, ADDR_CTRL, 32'h9C);
        inrush <= 1'b1;
        wt(1);
        inrush <= 1'b0;
        ocur <= 1'b1;
        wt(5);
        rdchk(ADDR_UNIT_STAT, 32'h0, "inrush masked");
        wt(INR + 10);
        rdchk(ADDR_UNIT_STAT, 32'h2, "overcurrent after");
        ocur <= 1'b0;
        $display("test inrush done");
        // shortest filter and extension selections
        wb(1'b1, ADDR_CTRL, 32'h0C);
        raw[2] <= 1'b1;
        wt(FILT_F + 2);
        chk("short filter on", 32'h4, 32'(cond));
        raw[2] <= 1'b0;
        wt(FILT_F + EXT_S);
        chk("short ext held", 32'h4, 32'(cond));
        wt(2);
        chk("short ext released", 32'h0, 32'(cond));
        // longest filter and extension selections
        wb(1'b1, ADDR_CTRL, 32'hFC);
        raw[2] <= 1'b1;
        wt(FILT_L - 4);
        chk("long filter wait", 32'h0, 32'(cond));
        wt(8);
        chk("long filter on", 32'h4, 32'(cond));
        raw[2] <= 1'b0;
        wt(FILT_L + EXT_L - 6);
        chk("long ext held", 32'h4, 32'(cond));
        wt(10);
        chk("long ext released", 32'h0, 32'(cond));
        $display("test filter selections done");
        wt(SAVE + N + 10);
        chk("save count", 32'h1, 32'(dic_field_model_i.save_cnt >= N));
        chk("saved ch1", 32'h1, dic_field_model_i.saved[1]);
        chk("saved ch3", 32'h0000_03E9, dic_field_model_i.saved[3]);
        $display("test storage done");
        report_and_stop();
    end
endmodule : testbench
